// >>> alz_pkg.sv
// constants shared by the ambient light zone engine
package alz_pkg;
    // register offsets
    localparam logic [7:0] ALZ_STATUS_OFS      = 8'h40;
    localparam logic [7:0] ALZ_CONTROL_OFS     = 8'h41;
    localparam logic [7:0] ALZ_RES_SEL_OFS     = 8'h42;
    localparam logic [7:0] ALZ_LIMIT0_OFS      = 8'h43;
    localparam logic [7:0] ALZ_TARGET0_OFS     = 8'h47;
    localparam logic [7:0] ALZ_GAIN_TRIP_OFS   = 8'h4C;
    localparam logic [7:0] ALZ_Z3_FALL_OFS     = 8'h4D;
    localparam logic [7:0] ALZ_GPO_CTRL_OFS    = 8'h52;
    // field positions
    localparam int ALZ_CTRL_AUTOGAIN_BIT       = 0;
    localparam int ALZ_CTRL_AVG_LSB            = 1;
    localparam int ALZ_GPO_ONE_BIT             = 0;
    localparam int ALZ_GPO_TWO_BIT             = 1;
    localparam int ALZ_STAT_FLAG_BIT           = 7;
    localparam int ALZ_STAT_GAIN_BIT           = 6;
    // reset values
    localparam logic [7:0] ALZ_CONTROL_RST     = 8'h00;
    localparam logic [4:0] ALZ_RES_SEL_RST     = 5'h00;
    localparam logic [7:0] ALZ_LIMIT_RST       = 8'hFF;
    localparam logic [6:0] ALZ_TARGET_RST      = 7'h00;
    localparam logic [7:0] ALZ_GAIN_TRIP_RST   = 8'h00;
    localparam logic [7:0] ALZ_Z3_FALL_RST     = 8'hFF;
    localparam logic [7:0] ALZ_GPO_CTRL_RST    = 8'h00;
    // timing
    localparam int ALZ_CLK_HZ                  = 100_000_000;
    localparam int ALZ_SAMPLE_HZ               = 16_000;
    localparam int ALZ_SAMPLE_CYCLES           = ALZ_CLK_HZ / ALZ_SAMPLE_HZ;
    localparam int ALZ_RAMP_STEP_US            = 50;
    localparam int ALZ_RAMP_STEP_CYCLES        = ALZ_RAMP_STEP_US * (ALZ_CLK_HZ / 1_000_000);
    localparam int ALZ_AVG_BASE_LOG2           = 4;
    typedef enum logic {
        ALZ_GAIN_HIGH = 1'b0,
        ALZ_GAIN_LOW  = 1'b1
    } alz_gain_t;
endpackage

// >>> alz_averager.sv
// sample averager over a selectable power-of-two window
`timescale 1ns/100ps
module alz_averager
    import alz_pkg::*;
#(
    parameter int BASE_LOG2 = ALZ_AVG_BASE_LOG2
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       sample_en_in,
    input  wire logic [7:0] sample_in,
    input  wire logic [2:0] avg_sel_in,
    output logic      [7:0] avg_out,
    output logic            avg_valid_out
);
    localparam int SUM_W = 8 + BASE_LOG2 + 8;
    logic [SUM_W-1:0] sum_reg, sum_next;
    logic [SUM_W-1:0] cnt_reg, cnt_next;
    logic [7:0]       avg_reg, avg_next;
    logic             valid_reg, valid_next;
    logic [SUM_W-1:0] total;
    logic [SUM_W-1:0] last;

    always_comb begin
        sum_next   = sum_reg;
        cnt_next   = cnt_reg;
        avg_next   = avg_reg;
        valid_next = 1'b0;
        total      = sum_reg + SUM_W'(sample_in);
        last       = (SUM_W'(1) << (BASE_LOG2 + 32'(avg_sel_in))) - SUM_W'(1);
        if (sample_en_in) begin
            if (cnt_reg >= last) begin // RULE9
                avg_next   = 8'(total >> (BASE_LOG2 + 32'(avg_sel_in)));
                valid_next = 1'b1;
                sum_next   = '0;
                cnt_next   = '0;
            end else begin
                sum_next = total; // RULE8
                cnt_next = cnt_reg + SUM_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sum_reg   <= '0;
            cnt_reg   <= '0;
            avg_reg   <= 8'h00;
            valid_reg <= 1'b0;
        end else begin
            sum_reg   <= sum_next;
            cnt_reg   <= cnt_next;
            avg_reg   <= avg_next;
            valid_reg <= valid_next;
        end
    end

    assign avg_out       = avg_reg;
    assign avg_valid_out = valid_reg;
endmodule

// >>> alz_engine.sv
// ambient light zone engine top
// How it works
// RULE1: four 8-bit zone limit registers split the light range into five zones.
// RULE2: the filtered sensor code is compared against the four limits to find the zone.
// RULE3: on a zone change the 7-bit brightness steps gradually to the new zone's target.
// RULE4: a zone change pulls the open-drain interrupt pin low until status is read.
// RULE5: a 5-bit resistor select picks one of 31 loads, all zeros leaves the input high impedance.
// RULE6: with auto gain off each general output follows its bit in the general output register.
// RULE7: auto gain drives outputs 0/1 for low gain and 1/0 for high gain.
// RULE8: the sensor is sampled at a fixed 16 kHz and samples feed the averager.
// RULE9: eight averaging periods are selectable and one result is passed on per period.
// RULE10: a new zone is accepted after two agreeing averages, so up to three periods late.
// RULE11: with auto gain, stepping from zone two to zone three selects low gain.
// RULE12: in low gain a level at or below the gain-raise trip selects high gain again.
// RULE13: in low gain the zone three-to-two step uses its own fall limit register.
// RULE14: enabling auto gain starts in high gain.
// RULE15: with auto gain, zones zero and four are never joined directly; gain changes in between.
// RULE16: the zone is the count of limits that the filtered code meets or exceeds.
`timescale 1ns/100ps
module alz_engine
    import alz_pkg::*;
#(
    parameter int SAMPLE_CYCLES = ALZ_SAMPLE_CYCLES,
    parameter int RAMP_CYCLES   = ALZ_RAMP_STEP_CYCLES
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    output logic            sample_req_out,
    input  wire logic [7:0] sensor_code_in,
    output logic      [4:0] sensor_resistor_select_out,
    output logic            sensor_input_hiz_out,
    output logic      [6:0] led_brightness_out,
    output logic      [2:0] zone_out,
    output logic            irq_pad_out,
    output logic            irq_oe_n_out,
    output logic            general_output_one,
    output logic            general_output_two
);
    // zone index from code and four limits
    function automatic logic [2:0] zone_count(input logic [7:0] code, input logic [7:0] l0,
                                              input logic [7:0] l1, input logic [7:0] l2,
                                              input logic [7:0] l3);
        logic [2:0] n;
        n = 3'd0;
        if (code >= l0) begin
            n = n + 3'd1;
        end
        if (code >= l1) begin
            n = n + 3'd1;
        end
        if (code >= l2) begin
            n = n + 3'd1;
        end
        if (code >= l3) begin
            n = n + 3'd1;
        end
        return n; // RULE16
    endfunction


    // register file
    logic [7:0] control_reg, control_next;
    logic [4:0] res_sel_reg, res_sel_next;
    logic [7:0] zone_limits [4];
    logic [7:0] zone_limits_next [4];
    logic [6:0] targets_reg [5];
    logic [6:0] targets_next [5];
    logic [7:0] gain_raise_trip_level, gain_raise_trip_level_next;
    logic [7:0] lowgain_zone3_fall_limit, lowgain_zone3_fall_limit_next;
    logic [7:0] gpo_ctrl_reg, gpo_ctrl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       status_rd;

    // engine state

    logic [$clog2(SAMPLE_CYCLES)-1:0] samp_cnt_reg, samp_cnt_next;
    logic                              samp_en_reg, samp_en_next;
    logic [$clog2(RAMP_CYCLES)-1:0]   ramp_cnt_reg, ramp_cnt_next;
    logic [2:0]  zone_reg, zone_next;
    logic [2:0]  cand_reg, cand_next;
    logic        flag_reg, flag_next;
    alz_gain_t   gain_reg, gain_next;
    logic        autogain_d_reg, autogain_d_next;
    logic [6:0]  bright_reg, bright_next;

    logic [7:0]  avg_code;
    logic        avg_valid;
    logic        autogain;
    logic [2:0]  raw_zone;
    logic [6:0]  target;

    assign autogain  = control_reg[ALZ_CTRL_AUTOGAIN_BIT];
    assign status_rd = reg_rd_in && (reg_addr_in == ALZ_STATUS_OFS);

    always_comb begin
        control_next                  = control_reg;
        res_sel_next                  = res_sel_reg;
        zone_limits_next              = zone_limits;
        targets_next                  = targets_reg;
        gain_raise_trip_level_next    = gain_raise_trip_level;
        lowgain_zone3_fall_limit_next = lowgain_zone3_fall_limit;
        gpo_ctrl_next                 = gpo_ctrl_reg;
        rdata_next                    = rdata_reg;
        // register writes
        if (reg_wr_in) begin
            if (reg_addr_in == ALZ_CONTROL_OFS) begin
                control_next = reg_wdata_in;
            end
            if (reg_addr_in == ALZ_RES_SEL_OFS) begin
                res_sel_next = reg_wdata_in[4:0]; // RULE5
            end
            for (int i = 0; i < 4; i++) begin
                if (reg_addr_in == ALZ_LIMIT0_OFS + 8'(i)) begin
                    zone_limits_next[i] = reg_wdata_in; // RULE1
                end
            end
            for (int i = 0; i < 5; i++) begin
                if (reg_addr_in == ALZ_TARGET0_OFS + 8'(i)) begin
                    targets_next[i] = reg_wdata_in[6:0];
                end
            end
            if (reg_addr_in == ALZ_GAIN_TRIP_OFS) begin
                gain_raise_trip_level_next = reg_wdata_in;
            end
            if (reg_addr_in == ALZ_Z3_FALL_OFS) begin
                lowgain_zone3_fall_limit_next = reg_wdata_in;
            end
            if (reg_addr_in == ALZ_GPO_CTRL_OFS) begin
                gpo_ctrl_next = {6'h00, reg_wdata_in[1:0]};
            end
        end
        // register reads, unmapped offsets return zero
        if (reg_rd_in) begin
            rdata_next = 8'h00;
            if (reg_addr_in == ALZ_STATUS_OFS) begin
                rdata_next = {flag_reg, gain_reg, 3'h0, zone_reg};
            end
            if (reg_addr_in == ALZ_CONTROL_OFS) begin
                rdata_next = control_reg;
            end
            if (reg_addr_in == ALZ_RES_SEL_OFS) begin
                rdata_next = {3'h0, res_sel_reg};
            end
            for (int i = 0; i < 4; i++) begin
                if (reg_addr_in == ALZ_LIMIT0_OFS + 8'(i)) begin
                    rdata_next = zone_limits[i];
                end
            end
            for (int i = 0; i < 5; i++) begin
                if (reg_addr_in == ALZ_TARGET0_OFS + 8'(i)) begin
                    rdata_next = {1'b0, targets_reg[i]};
                end
            end
            if (reg_addr_in == ALZ_GAIN_TRIP_OFS) begin
                rdata_next = gain_raise_trip_level;
            end
            if (reg_addr_in == ALZ_Z3_FALL_OFS) begin
                rdata_next = lowgain_zone3_fall_limit;
            end
            if (reg_addr_in == ALZ_GPO_CTRL_OFS) begin
                rdata_next = gpo_ctrl_reg;
            end
        end
    end


    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            control_reg              <= ALZ_CONTROL_RST;
            res_sel_reg              <= ALZ_RES_SEL_RST;
            for (int i = 0; i < 4; i++) begin
                zone_limits[i] <= ALZ_LIMIT_RST;
            end
            for (int i = 0; i < 5; i++) begin
                targets_reg[i] <= ALZ_TARGET_RST;
            end
            gain_raise_trip_level    <= ALZ_GAIN_TRIP_RST;
            lowgain_zone3_fall_limit <= ALZ_Z3_FALL_RST;
            gpo_ctrl_reg             <= ALZ_GPO_CTRL_RST;
            rdata_reg                <= 8'h00;
        end else begin
            control_reg              <= control_next;
            res_sel_reg              <= res_sel_next;
            zone_limits              <= zone_limits_next;
            targets_reg              <= targets_next;
            gain_raise_trip_level    <= gain_raise_trip_level_next;
            lowgain_zone3_fall_limit <= lowgain_zone3_fall_limit_next;
            gpo_ctrl_reg             <= gpo_ctrl_next;
            rdata_reg                <= rdata_next;
        end
    end

    alz_averager #(
        .BASE_LOG2     (ALZ_AVG_BASE_LOG2)
    ) u_avg (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .sample_en_in  (samp_en_reg),
        .sample_in     (sensor_code_in),
        .avg_sel_in    (control_reg[ALZ_CTRL_AVG_LSB +: 3]),
        .avg_out       (avg_code),
        .avg_valid_out (avg_valid)
    );

    // zone candidate per gain mode
    always_comb begin
        if (autogain && gain_reg == ALZ_GAIN_LOW) begin
            raw_zone = zone_count(avg_code, zone_limits[0], zone_limits[1],
                                  lowgain_zone3_fall_limit, zone_limits[3]); // RULE13
            if (raw_zone < 3'd2) begin
                raw_zone = 3'd2; // RULE15
            end
        end else begin
            raw_zone = zone_count(avg_code, zone_limits[0], zone_limits[1],
                                  zone_limits[2], zone_limits[3]); // RULE2
            if (autogain && raw_zone > 3'd3) begin
                raw_zone = 3'd3; // RULE15
            end
        end
    end

    // brightness target of the accepted zone
    assign target = targets_reg[zone_reg];

    // sampler, discriminator, gain and ramp

    always_comb begin
        samp_cnt_next   = samp_cnt_reg + 1'b1;
        samp_en_next    = 1'b0;
        ramp_cnt_next   = ramp_cnt_reg + 1'b1;
        zone_next       = zone_reg;
        cand_next       = cand_reg;
        flag_next       = flag_reg;
        gain_next       = gain_reg;
        autogain_d_next = autogain;
        bright_next     = bright_reg;
        if (samp_cnt_reg == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1)) begin
            samp_cnt_next = '0;
            samp_en_next  = 1'b1; // RULE8
        end
        if (status_rd) begin
            flag_next = 1'b0;
        end
        if (avg_valid) begin
            cand_next = raw_zone;
            if (raw_zone == cand_reg && raw_zone != zone_reg) begin
                zone_next = raw_zone; // RULE10
                flag_next = 1'b1; // RULE4
                if (autogain && gain_reg == ALZ_GAIN_HIGH && raw_zone == 3'd3) begin
                    gain_next = ALZ_GAIN_LOW; // RULE11
                end
            end
            if (autogain && gain_reg == ALZ_GAIN_LOW && avg_code <= gain_raise_trip_level) begin
                gain_next = ALZ_GAIN_HIGH; // RULE12
            end
        end
        if (autogain && !autogain_d_reg) begin
            gain_next = ALZ_GAIN_HIGH; // RULE14
        end
        if (ramp_cnt_reg == ($clog2(RAMP_CYCLES))'(RAMP_CYCLES - 1)) begin
            ramp_cnt_next = '0;
            if (bright_reg < target) begin
                bright_next = bright_reg + 7'd1; // RULE3
            end else if (bright_reg > target) begin
                bright_next = bright_reg - 7'd1; // RULE3
            end
        end
    end


    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            samp_cnt_reg   <= '0;
            samp_en_reg    <= 1'b0;
            ramp_cnt_reg   <= '0;
            zone_reg       <= 3'd0;
            cand_reg       <= 3'd0;
            flag_reg       <= 1'b0;
            gain_reg       <= ALZ_GAIN_HIGH;
            autogain_d_reg <= 1'b0;
            bright_reg     <= 7'h00;
        end else begin
            samp_cnt_reg   <= samp_cnt_next;
            samp_en_reg    <= samp_en_next;
            ramp_cnt_reg   <= ramp_cnt_next;
            zone_reg       <= zone_next;
            cand_reg       <= cand_next;
            flag_reg       <= flag_next;
            gain_reg       <= gain_next;
            autogain_d_reg <= autogain_d_next;
            bright_reg     <= bright_next;
        end
    end

    // output pins
    assign reg_rdata_out              = rdata_reg;
    assign sample_req_out             = samp_en_reg;
    assign sensor_resistor_select_out = res_sel_reg;
    assign sensor_input_hiz_out       = (res_sel_reg == 5'h00); // RULE5
    assign led_brightness_out         = bright_reg;
    assign zone_out                   = zone_reg;
    assign irq_pad_out                = 1'b0;
    assign irq_oe_n_out               = ~flag_reg; // RULE4
    assign general_output_one = autogain ? (gain_reg == ALZ_GAIN_HIGH)
                                         : gpo_ctrl_reg[ALZ_GPO_ONE_BIT]; // RULE6 RULE7
    assign general_output_two = autogain ? (gain_reg == ALZ_GAIN_LOW)
                                         : gpo_ctrl_reg[ALZ_GPO_TWO_BIT]; // RULE6 RULE7
endmodule

// >>> alz_engine_chk.sv
// assertion checker on the zone engine ports
`timescale 1ns/100ps
module alz_engine_chk
    import alz_pkg::*;
#(
    parameter int SAMPLE_CYCLES = ALZ_SAMPLE_CYCLES,
    parameter int RAMP_CYCLES   = ALZ_RAMP_STEP_CYCLES
) (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       sample_req_out,
    input wire logic [4:0] sensor_resistor_select_out,
    input wire logic       sensor_input_hiz_out,
    input wire logic [6:0] led_brightness_out,
    input wire logic [2:0] zone_out,
    input wire logic       irq_pad_out,
    input wire logic       irq_oe_n_out
);
    int         gap_reg, gap_next, still_reg, still_next;
    logic       seen_reg, seen_next;
    logic [6:0] led_reg, led_next;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    always_comb begin
        gap_next = sample_req_out ? 0 : gap_reg + 1;
        seen_next = seen_reg | sample_req_out;
        still_next = (led_brightness_out != led_reg) ? 0 : still_reg + 1;
        led_next = led_brightness_out;
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            gap_reg <= 0;
            seen_reg <= 1'b0;
            still_reg <= 0;
            led_reg <= 7'h00;
        end else begin
            gap_reg <= gap_next;
            seen_reg <= seen_next;
            still_reg <= still_next;
            led_reg <= led_next;
        end
    end
    hiz_level_a: assert property (
        sensor_input_hiz_out == (sensor_resistor_select_out == 5'h00)) else $error("hiz flag wrong");
    irq_pad_a: assert property (
        irq_pad_out == 1'b0) else $error("interrupt pad not low");
    irq_zone_a: assert property (
        $changed(zone_out) |-> ##[0:1] !irq_oe_n_out) else $error("zone change without interrupt");
    zone_max_a: assert property (
        zone_out <= 3'h4) else $error("zone above four");
    ramp_step_a: assert property (
        $changed(led_brightness_out) |-> (led_brightness_out - $past(led_brightness_out) == 7'h01)
        || ($past(led_brightness_out) - led_brightness_out == 7'h01)) else $error("brightness jumped");
    ramp_rate_a: assert property (
        $changed(led_brightness_out) |-> still_reg >= RAMP_CYCLES - 1) else $error("ramp too fast");
    sample_gap_a: assert property (
        sample_req_out && seen_reg |-> gap_reg == SAMPLE_CYCLES - 1) else $error("sample rate wrong");
    sample_pulse_a: assert property (
        sample_req_out |=> !sample_req_out) else $error("sample request too long");
    rdata_hold_a: assert property (
        !$past(reg_rd_in) |-> $stable(reg_rdata_out)) else $error("read data moved");
endmodule
bind alz_engine alz_engine_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .RAMP_CYCLES(RAMP_CYCLES)) alz_engine_chk_inst (
    .mclk_in, .rst_in, .reg_rd_in, .reg_rdata_out, .sample_req_out, .sensor_resistor_select_out,
    .sensor_input_hiz_out, .led_brightness_out, .zone_out, .irq_pad_out, .irq_oe_n_out);

// >>> alz_sensor_model.sv
// light sensor with gain pins answering sample requests
`timescale 1ns/100ps
module alz_sensor_model (
    input  wire logic       sample_req_in,
    input  wire logic       gain_one_in,
    input  wire logic       gain_two_in,
    input  wire logic [7:0] level_in,
    output logic      [7:0] code_out
);
    logic [7:0] value;
    // low gain halves the code
    assign value = (!gain_one_in && gain_two_in) ? level_in >> 1 : level_in;
    // code only valid in the sample cycle
    assign code_out = sample_req_in ? value : ~value;
endmodule

// >>> testbench.sv
// self-checking bench for the zone engine
`timescale 1ns/100ps
module testbench;
    import alz_pkg::*;
    localparam int SC = 8;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, level = 8'h00, d, reg_rdata_out, sensor_code_in;
    logic       mclk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic       sample_req_out, sensor_input_hiz_out, irq_pad_out, irq_oe_n_out;
    logic       general_output_one, general_output_two;
    logic [4:0] sensor_resistor_select_out;
    logic [6:0] led_brightness_out;
    logic [2:0] zone_out;
    int         err_count = 0, tests_run = 0, n, lv, tgt[5], z4 = 0;
    int         lim[4] = '{32, 64, 96, 128};
    int         zseq[5] = '{4, 1, 3, 0, 2};
    logic [7:0] rofs[6] = '{8'h41, 8'h43, 8'h4C, 8'h4D, 8'h52, 8'h50};
    logic [7:0] rexp[6] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (zone_out === 3'h4) z4 <= z4 + 1;
    alz_engine #(.SAMPLE_CYCLES(SC), .RAMP_CYCLES(4)) alz_engine_inst (.mclk_in, .rst_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sample_req_out, .sensor_code_in,
        .sensor_resistor_select_out, .sensor_input_hiz_out, .led_brightness_out, .zone_out, .irq_pad_out,
        .irq_oe_n_out, .general_output_one, .general_output_two);
    alz_sensor_model alz_sensor_model_inst (.sample_req_in(sample_req_out), .gain_one_in(general_output_one),
        .gain_two_in(general_output_two), .level_in(level), .code_out(sensor_code_in));
    function automatic int zone_of(input int c, input int l2);
        zone_of = 0;
        for (int k = 0; k < 4; k++) zone_of += (c >= ((k == 2) ? l2 : lim[k]));
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask
    task automatic settle(input int z, input logic g, input int per);
        n = 0;
        while (zone_out !== 3'(z) && n < 6 * per) begin
            @(posedge mclk_in);
            #1 n++;
        end
        chk({7'h0, n <= 4 * per}, 8'h01);
        chk({5'h0, zone_out}, 8'(z));
        if (n >= 6 * per) close_out();
        chk({7'h0, irq_oe_n_out}, 8'h00);
        rd(ALZ_STATUS_OFS, d);
        chk(d, {1'b1, g, 3'h0, 3'(z)});
        chk({7'h0, irq_oe_n_out}, 8'h01);
        n = 0;
        while (led_brightness_out !== 7'(tgt[z]) && n < 2000) begin
            @(posedge mclk_in);
            #1 n++;
        end
        chk({1'b0, led_brightness_out}, 8'(tgt[z]));
        if (n >= 2000) close_out();
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        n = $urandom(69);
        for (int z = 0; z < 5; z++) tgt[z] = $urandom % 128;
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        foreach (rofs[i]) begin
            rd(rofs[i], d);
            chk(d, rexp[i]);
        end
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h1F : 8'($urandom % 31 + 1);
            wr(ALZ_RES_SEL_OFS, d);
            #1 chk({3'h0, sensor_resistor_select_out}, d);
            chk({7'h0, sensor_input_hiz_out}, {7'h0, d == 8'h00});
            wr(ALZ_GPO_CTRL_OFS, 8'(i));
            #1 chk({6'h0, general_output_two, general_output_one}, 8'(i));
        end
        $display("test resistor and outputs done");
        for (int k = 0; k < 5; k++) begin
            if (k < 4) wr(ALZ_LIMIT0_OFS + 8'(k), 8'(lim[k]));
            wr(ALZ_TARGET0_OFS + 8'(k), 8'(tgt[k]));
        end
        foreach (zseq[i]) begin
            wr(ALZ_CONTROL_OFS, 8'((i % 2) << 1));
            lv = zseq[i] * 32 + $urandom % 32;
            level <= 8'(lv);
            settle(zone_of(lv, lim[2]), 1'b0, (16 << (i % 2)) * SC);
        end
        $display("test zones done");
        level <= 8'h10;
        settle(zone_of(16, lim[2]), 1'b0, 16 * SC);
        n = z4;
        wr(ALZ_GAIN_TRIP_OFS, 8'h10);
        wr(ALZ_Z3_FALL_OFS, 8'h30);
        wr(ALZ_CONTROL_OFS, 8'h01);
        #1 chk({6'h0, general_output_two, general_output_one}, 8'h01);
        level <= 8'h90;
        lv = n;
        settle(zone_of(8'h48, 8'h30), 1'b1, 16 * SC);
        chk({6'h0, general_output_two, general_output_one}, 8'h02);
        level <= 8'h10;
        settle(zone_of(16, lim[2]), 1'b0, 32 * SC);
        chk({6'h0, general_output_two, general_output_one}, 8'h01);
        chk(8'(z4 - lv), 8'h00);
        $display("test auto gain done");
        close_out();
    end
endmodule
